/* File: hw/mhsp_pkg.sv */
// Package of constants and carrier types for the modem host serial status port
package mhsp_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;

  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned CONFIRM_S = 20;
  localparam int unsigned CONFIRM_CYCLES = CLK_HZ * CONFIRM_S;

  localparam logic [11:0] BAT_LOW_MV = 12'h0DAC;
  localparam logic [11:0] BAT_OK_MV = 12'h0E10;

  // Avalon register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_TXDATA = 8'h10;
  localparam logic [7:0] REG_RXDATA = 8'h14;
  localparam logic [7:0] REG_BAUD = 8'h18;
  localparam logic [7:0] REG_SUPPLY = 8'h1C;

  // Control bit positions
  localparam int unsigned CTRL_READY = 0;
  localparam int unsigned CTRL_IN_RANGE = 1;
  localparam int unsigned CTRL_THROTTLE = 2;
  localparam int unsigned CTRL_MSG_IN = 3;
  localparam int unsigned CTRL_MSG_OUT = 4;
  localparam int unsigned CTRL_POWER_ON = 5;
  localparam int unsigned CTRL_LOCKED = 6;
  localparam int unsigned CTRL_RADIO_TX = 7;
  localparam int unsigned CTRL_RADIO_RX = 8;
  localparam int unsigned CTRL_WIDTH = 9;

  // Interrupt bit positions
  localparam int unsigned IRQ_RX = 0;
  localparam int unsigned IRQ_TX_DONE = 1;
  localparam int unsigned IRQ_FRAME_ERR = 2;
  localparam int unsigned IRQ_BATT = 3;
  localparam int unsigned IRQ_WIDTH = 4;

  typedef struct packed {
    logic carrier_n;
    logic ready_n;
    logic throttle;
    logic ring_n;
  } mhsp_modem_ctl_t;

  typedef struct packed {
    logic msg_pending_ind_n;
    logic coverage_ind_n;
    logic supply_low_ind_n;
  } mhsp_ext_ind_t;

  typedef struct packed {
    logic power;
    logic radio_tx;
    logic radio_rx;
  } mhsp_led_t;

  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} mhsp_ser_state_t;

endpackage : mhsp_pkg

/* File: hw/mhsp_rx.sv */
// Serial character receiver for the host link
`timescale 1ns/10ps
module mhsp_rx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Configuration
  input wire logic [15:0] i_baud_div,
  // Serial line from the host
  input wire logic i_serial,
  // Received character
  output logic [7:0] o_data,
  output logic o_valid,
  output logic o_frame_err
);
  mhsp_pkg::mhsp_ser_state_t state;
  logic [15:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] shift;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= mhsp_pkg::S_IDLE;
      cnt <= 16'h0000;
      bit_idx <= 3'h0;
      shift <= 8'h00;
      o_data <= 8'h00;
      o_valid <= 1'b0;
      o_frame_err <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      o_frame_err <= 1'b0;
      unique case (state)
        mhsp_pkg::S_IDLE: begin
          cnt <= {1'b0, i_baud_div[15:1]};
          if (!i_serial) begin // RQ16
            state <= mhsp_pkg::S_START;
          end
        end
        mhsp_pkg::S_START: begin
          if (cnt == 16'h0000) begin
            cnt <= i_baud_div - 16'h0001;
            bit_idx <= 3'h0;
            state <= i_serial ? mhsp_pkg::S_IDLE : mhsp_pkg::S_DATA;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        mhsp_pkg::S_DATA: begin
          if (cnt == 16'h0000) begin
            cnt <= i_baud_div - 16'h0001;
            shift <= {i_serial, shift[7:1]}; // RQ16
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'(mhsp_pkg::DATA_BITS - 1)) begin // RQ1
              state <= mhsp_pkg::S_STOP;
            end
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        mhsp_pkg::S_STOP: begin
          if (cnt == 16'h0000) begin
            state <= mhsp_pkg::S_IDLE;
            if (i_serial) begin // RQ1
              o_data <= shift;
              o_valid <= 1'b1;
            end else begin
              o_frame_err <= 1'b1;
            end
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
      endcase
    end
  end
endmodule : mhsp_rx

/* File: hw/mhsp_top.sv */
// Modem host serial port with modem control, status outputs and indicators
//
// Function
// RQ1 - Each host link character carries 8 data bits, no parity and 1 stop bit.
// RQ2 - The host link runs at 9600 bit/s until software sets another rate.
// RQ3 - Carrier detect is low while in range and high otherwise.
// RQ4 - Terminal ready from the host and data set ready from the modem are both active low.
// RQ5 - While the host holds request-to-send high the modem pauses sending to it.
// RQ6 - The modem raises clear-to-send to make the host pause sending.
// RQ7 - Ring indicator pulses low while messages wait and rests high otherwise.
// RQ8 - Message pending output is low while an inbound or outbound message is pending.
// RQ9 - Coverage output is low when in range and follows carrier detect exactly.
// RQ10 - Supply low output falls below 3.5 V and rises only above 3.6 V.
// RQ11 - Supply low output changes with the low supply event, confirmed within 20 s.
// RQ12 - Power indicator flashes while scanning, is steady when locked and dark when off.
// RQ13 - Transmit indicator flashes while radio data is transmitted.
// RQ14 - Receive indicator flashes while radio data is received.
// RQ15 - The four general status lines are reserved and perform no function.
// RQ16 - Characters use a low start bit, data LSB first, then stop; the line idles high.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module mhsp_top #(
  parameter int unsigned CONFIRM_CYCLES = mhsp_pkg::CONFIRM_CYCLES,
  parameter int unsigned FLASH_CYCLES = mhsp_pkg::FLASH_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  // Host serial link
  input wire logic i_host_serial_in,
  output logic o_host_serial_out,
  input wire logic i_terminal_ready_n,
  input wire logic i_host_throttle,
  output mhsp_pkg::mhsp_modem_ctl_t o_modem_ctl,
  // Reserved general status lines
  input wire logic [3:0] i_gen_status_line,
  output logic [3:0] o_gen_status_line,
  output logic [3:0] o_gen_status_line_oe,
  // Status and indicators
  output mhsp_pkg::mhsp_ext_ind_t o_ext_ind,
  output mhsp_pkg::mhsp_led_t o_led
);
  logic [mhsp_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [15:0] baud_div;
  logic [11:0] supply_mv;
  logic [mhsp_pkg::IRQ_WIDTH-1:0] irq_stat;
  logic [mhsp_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [mhsp_pkg::IRQ_WIDTH-1:0] irq_evt;

  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_frame_err;
  logic [7:0] rx_hold;
  logic rx_full;

  logic [7:0] tx_hold;
  logic tx_full;
  mhsp_pkg::mhsp_ser_state_t tx_state;
  logic [15:0] tx_cnt;
  logic [2:0] tx_idx;
  logic [7:0] tx_shift;
  logic tx_done;

  logic access;
  logic ack;
  logic wr;
  logic rd;

  logic supply_low_raw;
  logic supply_low;
  logic [31:0] confirm_cnt;
  logic confirm_due;

  logic [31:0] flash_cnt;
  logic flash;
  logic ring_phase;
  logic msg_pending;

  // One wait cycle per access; the answer is given on the second edge
  assign access = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = access & ~ack;
  assign wr = i_avs_write & ack;
  assign rd = i_avs_read & ack;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= access & ~ack;
    end
  end

  // Control, baud and supply registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= '0;
      baud_div <= mhsp_pkg::BAUD_DIV_RESET; // RQ2
      supply_mv <= 12'h000;
    end else if (wr) begin
      if (i_avs_address == mhsp_pkg::REG_CTRL && i_avs_byteenable[0]) begin
        ctrl[7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_address == mhsp_pkg::REG_CTRL && i_avs_byteenable[1]) begin
        ctrl[8] <= i_avs_writedata[8];
      end
      // Divisors below four leave no room for the mid-bit sample
      if (i_avs_address == mhsp_pkg::REG_BAUD && i_avs_byteenable[1:0] == 2'b11
          && i_avs_writedata[15:0] >= 16'h0004) begin
        baud_div <= i_avs_writedata[15:0];
      end
      if (i_avs_address == mhsp_pkg::REG_SUPPLY && i_avs_byteenable[1:0] == 2'b11) begin
        supply_mv <= i_avs_writedata[11:0];
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_mask <= '0;
    end else if (wr && i_avs_address == mhsp_pkg::REG_IRQ_MASK && i_avs_byteenable[0]) begin
      irq_mask <= i_avs_writedata[mhsp_pkg::IRQ_WIDTH-1:0];
    end
  end

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_stat <= '0;
    end else begin
      for (int i = 0; i < mhsp_pkg::IRQ_WIDTH; i++) begin
        if (irq_evt[i]) begin
          irq_stat[i] <= 1'b1;
        end else if (wr && i_avs_address == mhsp_pkg::REG_IRQ_STAT && i_avs_byteenable[0]
                     && i_avs_writedata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  // Read data
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (access && !ack) begin
      unique case (i_avs_address)
        mhsp_pkg::REG_CTRL: o_avs_readdata <= 32'(ctrl);
        mhsp_pkg::REG_STATUS: o_avs_readdata <= {22'h00_0000, rx_full, tx_full, tx_state != mhsp_pkg::S_IDLE,
                                                  supply_low, i_host_throttle, ~i_terminal_ready_n,
                                                  o_modem_ctl};
        mhsp_pkg::REG_IRQ_STAT: o_avs_readdata <= 32'(irq_stat);
        mhsp_pkg::REG_IRQ_MASK: o_avs_readdata <= 32'(irq_mask);
        mhsp_pkg::REG_TXDATA: o_avs_readdata <= {24'h00_0000, tx_hold};
        mhsp_pkg::REG_RXDATA: o_avs_readdata <= {24'h00_0000, rx_hold};
        mhsp_pkg::REG_BAUD: o_avs_readdata <= {16'h0000, baud_div};
        mhsp_pkg::REG_SUPPLY: o_avs_readdata <= {20'h0_0000, supply_mv};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Receiver
  mhsp_rx u_rx (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_baud_div(baud_div),
    .i_serial(i_host_serial_in),
    .o_data(rx_data),
    .o_valid(rx_valid),
    .o_frame_err(rx_frame_err)
  );

  // Receive holding register; reading it frees the slot
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_valid) begin
      rx_hold <= rx_data;
      rx_full <= 1'b1;
    end else if (rd && i_avs_address == mhsp_pkg::REG_RXDATA) begin
      rx_full <= 1'b0;
    end
  end

  // Transmit holding register, written by software
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_hold <= 8'h00;
      tx_full <= 1'b0;
    end else if (wr && i_avs_address == mhsp_pkg::REG_TXDATA && i_avs_byteenable[0] && !tx_full) begin
      tx_hold <= i_avs_writedata[7:0];
      tx_full <= 1'b1;
    end else if (tx_state == mhsp_pkg::S_IDLE && tx_full && !i_host_throttle) begin // RQ5
      tx_full <= 1'b0;
    end
  end

  // Transmitter: a character already started finishes, a new one waits
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_state <= mhsp_pkg::S_IDLE;
      tx_cnt <= 16'h0000;
      tx_idx <= 3'h0;
      tx_shift <= 8'h00;
      o_host_serial_out <= 1'b1; // RQ16
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      unique case (tx_state)
        mhsp_pkg::S_IDLE: begin
          o_host_serial_out <= 1'b1; // RQ16
          if (tx_full && !i_host_throttle) begin // RQ5
            tx_shift <= tx_hold;
            tx_cnt <= baud_div - 16'h0001;
            o_host_serial_out <= 1'b0; // RQ16
            tx_state <= mhsp_pkg::S_START;
          end
        end
        mhsp_pkg::S_START: begin
          if (tx_cnt == 16'h0000) begin
            tx_cnt <= baud_div - 16'h0001;
            tx_idx <= 3'h0;
            o_host_serial_out <= tx_shift[0]; // RQ16
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_state <= mhsp_pkg::S_DATA;
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
        mhsp_pkg::S_DATA: begin
          if (tx_cnt == 16'h0000) begin
            tx_cnt <= baud_div - 16'h0001;
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == 3'(mhsp_pkg::DATA_BITS - 1)) begin // RQ1
              o_host_serial_out <= 1'b1;
              tx_state <= mhsp_pkg::S_STOP;
            end else begin
              o_host_serial_out <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[7:1]};
            end
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
        mhsp_pkg::S_STOP: begin
          if (tx_cnt == 16'h0000) begin // RQ1
            tx_state <= mhsp_pkg::S_IDLE;
            tx_done <= 1'b1;
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
      endcase
    end
  end

  // Supply hysteresis and confirmation delay
  // A zero supply reading after reset counts as low until software writes it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      supply_low_raw <= 1'b0;
    end else if (supply_mv < mhsp_pkg::BAT_LOW_MV) begin // RQ10
      supply_low_raw <= 1'b1;
    end else if (supply_mv > mhsp_pkg::BAT_OK_MV) begin // RQ10
      supply_low_raw <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      supply_low <= 1'b0;
      confirm_cnt <= 32'h0000_0000;
    end else if (supply_low_raw == supply_low) begin
      confirm_cnt <= 32'h0000_0000;
    end else if (confirm_due) begin // RQ11
      supply_low <= supply_low_raw;
      confirm_cnt <= 32'h0000_0000;
    end else begin
      confirm_cnt <= confirm_cnt + 32'h0000_0001;
    end
  end

  assign irq_evt[mhsp_pkg::IRQ_RX] = rx_valid;
  assign irq_evt[mhsp_pkg::IRQ_TX_DONE] = tx_done;
  assign irq_evt[mhsp_pkg::IRQ_FRAME_ERR] = rx_frame_err;
  assign irq_evt[mhsp_pkg::IRQ_BATT] = (supply_low_raw != supply_low) && confirm_due;
  assign confirm_due = confirm_cnt >= CONFIRM_CYCLES - 1;

  // Shared flash timebase for indicators and ring pulses
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flash_cnt <= 32'h0000_0000;
      flash <= 1'b0;
    end else if (flash_cnt >= FLASH_CYCLES - 1) begin
      flash_cnt <= 32'h0000_0000;
      flash <= ~flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h0000_0001;
    end
  end

  assign msg_pending = ctrl[mhsp_pkg::CTRL_MSG_IN] | ctrl[mhsp_pkg::CTRL_MSG_OUT];
  assign ring_phase = msg_pending & flash;

  // Modem control and status outputs, all registered
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_modem_ctl <= '{carrier_n: 1'b1, ready_n: 1'b1, throttle: 1'b0, ring_n: 1'b1};
      o_ext_ind <= '{msg_pending_ind_n: 1'b1, coverage_ind_n: 1'b1, supply_low_ind_n: 1'b1};
      o_led <= '{power: 1'b0, radio_tx: 1'b0, radio_rx: 1'b0};
    end else begin
      o_modem_ctl.carrier_n <= ~ctrl[mhsp_pkg::CTRL_IN_RANGE]; // RQ3
      o_modem_ctl.ready_n <= ~ctrl[mhsp_pkg::CTRL_READY]; // RQ4
      o_modem_ctl.throttle <= ctrl[mhsp_pkg::CTRL_THROTTLE] | rx_full; // RQ6
      o_modem_ctl.ring_n <= ~ring_phase; // RQ7
      o_ext_ind.msg_pending_ind_n <= ~msg_pending; // RQ8
      o_ext_ind.coverage_ind_n <= ~ctrl[mhsp_pkg::CTRL_IN_RANGE]; // RQ9
      o_ext_ind.supply_low_ind_n <= ~supply_low; // RQ11
      o_led.power <= ctrl[mhsp_pkg::CTRL_POWER_ON] & (ctrl[mhsp_pkg::CTRL_LOCKED] | flash); // RQ12
      o_led.radio_tx <= ctrl[mhsp_pkg::CTRL_RADIO_TX] & flash; // RQ13
      o_led.radio_rx <= ctrl[mhsp_pkg::CTRL_RADIO_RX] & flash; // RQ14
    end
  end

  // General status lines are reserved: never driven
  assign o_gen_status_line = 4'h0; // RQ15
  assign o_gen_status_line_oe = 4'h0; // RQ15

endmodule : mhsp_top

/* File: verification/mhsp_chk.sv */
// Port checker of the modem host serial status port
`timescale 1ns/10ps
module mhsp_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register bus
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  // Host link and status
  input wire logic o_host_serial_out,
  input wire mhsp_pkg::mhsp_modem_ctl_t o_modem_ctl,
  input wire logic [3:0] o_gen_status_line,
  input wire logic [3:0] o_gen_status_line_oe,
  input wire mhsp_pkg::mhsp_ext_ind_t o_ext_ind,
  input wire mhsp_pkg::mhsp_led_t o_led
);
  logic [8:0] ctl;
  logic req;
  assign req = i_avs_read | i_avs_write;
  // Shadow of the control register from committed writes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctl <= '0;
    end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == mhsp_pkg::REG_CTRL) begin
      if (i_avs_byteenable[0]) begin
        ctl[7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        ctl[8] <= i_avs_writedata[8];
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_carrier_range: assert property (ctl[1] == $past(ctl[1]) |-> o_modem_ctl.carrier_n == !ctl[1])
    else $error("carrier detect wrong");
  a_coverage_follows: assert property (o_ext_ind.coverage_ind_n == o_modem_ctl.carrier_n)
    else $error("coverage differs from carrier");
  a_ready_level: assert property (ctl[0] == $past(ctl[0]) |-> o_modem_ctl.ready_n == !ctl[0])
    else $error("ready output wrong");
  a_cts_throttle: assert property (ctl[2] && $past(ctl[2]) |-> o_modem_ctl.throttle)
    else $error("clear to send not raised");
  a_ring_rest: assert property (!(ctl[3] | ctl[4]) [*2] |-> o_modem_ctl.ring_n)
    else $error("ring low with no message");
  a_msg_pending: assert property ((ctl[3] | ctl[4]) == ($past(ctl[3]) | $past(ctl[4]))
    |-> o_ext_ind.msg_pending_ind_n == !(ctl[3] | ctl[4]))
    else $error("message pending wrong");
  a_power_dark: assert property (!ctl[5] && !$past(ctl[5]) |-> !o_led.power)
    else $error("power lit while off");
  a_power_steady: assert property (ctl[5] && ctl[6] && $past(ctl[5]) && $past(ctl[6]) |-> o_led.power)
    else $error("power not steady when locked");
  a_gen_quiet: assert property (o_gen_status_line_oe == 4'h0 && o_gen_status_line == 4'h0)
    else $error("reserved lines active");
  a_start_len: assert property ($fell(o_host_serial_out) |=> !o_host_serial_out [*3])
    else $error("start bit too short");
  a_wait_once: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("second wait cycle");
endmodule : mhsp_chk

bind mhsp_top mhsp_chk mhsp_chk_inst (.i_clk, .i_reset_n, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_waitrequest, .o_host_serial_out, .o_modem_ctl,
  .o_gen_status_line, .o_gen_status_line_oe, .o_ext_ind, .o_led);

/* File: verification/mhsp_host_model.sv */
// Behavioural host serial port facing the modem
`timescale 1ns/10ps
module mhsp_host_model #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic i_clk,
  // Link to and from the modem
  input wire logic i_line,
  input wire logic i_cts,
  output logic o_line
);
  logic [7:0] got;
  logic got_stop;
  int got_n = 0;
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    while (i_cts !== 1'b0) @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      o_line <= f[i];
      repeat (BIT) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask : send
  // Samples each bit in its middle
  always begin
    @(negedge i_line);
    repeat (BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      got[i] = i_line;
    end
    repeat (BIT) @(posedge i_clk);
    got_stop = i_line;
    got_n++;
  end
endmodule : mhsp_host_model

/* File: verification/tb_top.sv */
// Testbench of the modem host serial status port
`timescale 1ns/10ps
module tb_top;
  logic i_clk;
  logic i_reset_n;
  logic [7:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic o_irq;
  logic i_host_serial_in;
  logic o_host_serial_out;
  logic i_terminal_ready_n;
  logic i_host_throttle;
  mhsp_pkg::mhsp_modem_ctl_t o_modem_ctl;
  logic [3:0] i_gen_status_line;
  logic [3:0] o_gen_status_line;
  logic [3:0] o_gen_status_line_oe;
  mhsp_pkg::mhsp_ext_ind_t o_ext_ind;
  mhsp_pkg::mhsp_led_t o_led;
  int fail_count;
  int compares;
  logic [31:0] rdv;
  mhsp_top #(.CONFIRM_CYCLES(20), .FLASH_CYCLES(4)) mhsp_top_inst (.i_clk, .i_reset_n, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_irq,
    .i_host_serial_in, .o_host_serial_out, .i_terminal_ready_n, .i_host_throttle, .o_modem_ctl,
    .i_gen_status_line, .o_gen_status_line, .o_gen_status_line_oe, .o_ext_ind, .o_led);
  mhsp_host_model #(.BIT(16)) mhsp_host_model_inst (.i_clk, .i_line(o_host_serial_out),
    .i_cts(o_modem_ctl.throttle), .o_line(i_host_serial_in));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic chb(input string n, input logic s, input logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask : chb
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= b;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rdv = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
    bus(1'b1, a, d, b);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : rd
  task automatic watch(output logic [31:0] p, t, r);
    p = 0;
    t = 0;
    r = 0;
    repeat (2) @(posedge i_clk);
    repeat (16) begin
      @(posedge i_clk);
      p += o_led.power;
      t += o_led.radio_tx;
      r += o_led.radio_rx;
    end
  endtask : watch
  task automatic t_reset();
    chb("serial idle", o_host_serial_out, 1'b1);
    chk("modem ctl", 32'(o_modem_ctl), 32'h0000_000D);
    chk("status out", 32'(o_ext_ind), 32'h0000_0007);
    wr(mhsp_pkg::REG_SUPPLY, 32'h0000_0E74);
    rd(mhsp_pkg::REG_BAUD);
    chk("baud", rdv, 32'(mhsp_pkg::BAUD_DIV_RESET));
    wr(mhsp_pkg::REG_BAUD, 32'h0000_0010);
    wr(mhsp_pkg::REG_BAUD, 32'h0000_0008, 4'h1);
    rd(mhsp_pkg::REG_BAUD);
    chk("baud lanes", rdv, 32'h0000_0010);
    rd(8'h40);
    chk("unmapped", rdv, 32'h0000_0000);
    chk("gen lines", {24'h0, o_gen_status_line, o_gen_status_line_oe}, 32'h0000_0000);
  endtask : t_reset
  task automatic t_ctl();
    wr(mhsp_pkg::REG_CTRL, 32'h0000_0007);
    repeat (2) @(posedge i_clk);
    chk("modem ctl", 32'(o_modem_ctl), 32'h0000_0003);
    chb("coverage", o_ext_ind.coverage_ind_n, 1'b0);
    rd(mhsp_pkg::REG_STATUS);
    chk("host lines", {30'h0, rdv[5:4]}, 32'h0000_0001);
    wr(mhsp_pkg::REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge i_clk);
    chb("coverage", o_ext_ind.coverage_ind_n, 1'b1);
  endtask : t_ctl
  task automatic t_tx();
    logic [31:0] lows;
    int n;
    lows = 0;
    n = mhsp_host_model_inst.got_n;
    wr(mhsp_pkg::REG_IRQ_MASK, 32'h0000_0002);
    i_host_throttle <= 1'b1;
    wr(mhsp_pkg::REG_TXDATA, 32'h0000_00A5);
    repeat (40) begin
      @(posedge i_clk);
      lows += !o_host_serial_out;
    end
    chk("held", lows, 0);
    i_host_throttle <= 1'b0;
    for (int i = 0; i < 400 && mhsp_host_model_inst.got_n == n; i++) @(posedge i_clk);
    chk("tx byte", {24'h0, mhsp_host_model_inst.got}, 32'h0000_00A5);
    chb("tx stop", mhsp_host_model_inst.got_stop, 1'b1);
    repeat (20) @(posedge i_clk);
    chb("irq", o_irq, 1'b1);
    wr(mhsp_pkg::REG_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge i_clk);
    chb("irq clear", o_irq, 1'b0);
  endtask : t_tx
  task automatic t_rx();
    wr(mhsp_pkg::REG_IRQ_MASK, 32'h0000_0000);
    mhsp_host_model_inst.send(8'h3C, 1'b1);
    repeat (4) @(posedge i_clk);
    chb("cts full", o_modem_ctl.throttle, 1'b1);
    chb("irq masked", o_irq, 1'b0);
    rd(mhsp_pkg::REG_IRQ_STAT);
    chk("irq stat", rdv, 32'h0000_0001);
    rd(mhsp_pkg::REG_RXDATA);
    chk("rx byte", rdv, 32'h0000_003C);
    wr(mhsp_pkg::REG_IRQ_STAT, 32'h0000_0001);
    mhsp_host_model_inst.send(8'h81, 1'b0);
    repeat (20) @(posedge i_clk);
    rd(mhsp_pkg::REG_IRQ_STAT);
    chb("frame err", rdv[2], 1'b1);
    wr(mhsp_pkg::REG_IRQ_STAT, 32'h0000_000F);
    rd(mhsp_pkg::REG_RXDATA);
  endtask : t_rx
  task automatic t_msg();
    logic [31:0] lows;
    for (int k = 3; k < 5; k++) begin
      lows = 0;
      wr(mhsp_pkg::REG_CTRL, 32'h0000_0001 << k);
      repeat (20) begin
        @(posedge i_clk);
        lows += !o_modem_ctl.ring_n;
      end
      chb("msg pending", o_ext_ind.msg_pending_ind_n, 1'b0);
      chb("ring pulses", lows > 0 && lows < 20, 1'b1);
    end
    wr(mhsp_pkg::REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge i_clk);
    chb("msg pending", o_ext_ind.msg_pending_ind_n, 1'b1);
    chb("ring rest", o_modem_ctl.ring_n, 1'b1);
  endtask : t_msg
  task automatic t_led();
    logic [31:0] p;
    logic [31:0] t;
    logic [31:0] r;
    wr(mhsp_pkg::REG_CTRL, 32'h0000_0020);
    watch(p, t, r);
    chb("power scan", p > 0 && p < 16, 1'b1);
    wr(mhsp_pkg::REG_CTRL, 32'h0000_0060);
    watch(p, t, r);
    chk("power lock", p, 16);
    wr(mhsp_pkg::REG_CTRL, 32'h0000_0180);
    watch(p, t, r);
    chk("power off", p, 0);
    chb("tx flash", t > 0 && t < 16, 1'b1);
    chb("rx flash", r > 0 && r < 16, 1'b1);
    wr(mhsp_pkg::REG_CTRL, 32'h0000_0000);
  endtask : t_led
  task automatic t_supply();
    wr(mhsp_pkg::REG_IRQ_MASK, 32'h0000_0008);
    wr(mhsp_pkg::REG_SUPPLY, 32'h0000_0D48);
    repeat (30) @(posedge i_clk);
    chb("supply low", o_ext_ind.supply_low_ind_n, 1'b0);
    chb("supply irq", o_irq, 1'b1);
    wr(mhsp_pkg::REG_IRQ_STAT, 32'h0000_0008);
    wr(mhsp_pkg::REG_SUPPLY, 32'h0000_0DDE);
    repeat (30) @(posedge i_clk);
    chb("supply band", o_ext_ind.supply_low_ind_n, 1'b0);
    chb("supply irq", o_irq, 1'b0);
    wr(mhsp_pkg::REG_SUPPLY, 32'h0000_0E74);
    repeat (30) @(posedge i_clk);
    chb("supply ok", o_ext_ind.supply_low_ind_n, 1'b1);
  endtask : t_supply
  initial begin
    i_reset_n = 1'b0;
    i_avs_address = 8'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'hF;
    i_terminal_ready_n = 1'b0;
    i_host_throttle = 1'b0;
    i_gen_status_line = 4'hA;
    fail_count = 0;
    compares = 0;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_ctl();
    t_tx();
    t_rx();
    t_msg();
    t_led();
    t_supply();
    stop_test();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    stop_test();
  end
endmodule : tb_top
